/* shared/blec_pkg.sv */
package blec_pkg;
   // Register offsets
   localparam logic [7:0] REG_ENABLE_OFS = 8'h10;
   localparam logic [7:0] REG_MAPCFG_OFS = 8'h11;
   localparam logic [7:0] REG_BRT_LO_OFS = 8'h14;
   localparam logic [7:0] REG_BRT_HI_OFS = 8'h15;
   localparam logic [7:0] REG_STATUS_OFS = 8'h16;
   // Field positions
   localparam int CHIP_EN_BIT = 0;
   localparam int SINK_EN_LSB = 1;
   localparam int MAP_EXP_BIT = 7;
   localparam int SRC_SEL_LSB = 0;
   localparam int BRT_LO_W = 3;
   // Reset values and writable masks
   localparam logic [7:0] ENABLE_RST = 8'h0F;
   localparam logic [7:0] ENABLE_MASK = 8'h0F;
   localparam logic [7:0] MAPCFG_RST = 8'h01;
   localparam logic [7:0] MAPCFG_MASK = 8'h83;
   localparam logic [10:0] BRT_RST = 11'h000;
   // Brightness source codes
   localparam logic [1:0] SRC_BUS = 2'h0;
   localparam logic [1:0] SRC_PWM = 2'h1;
   // Current mapping, in nanoamps; exponential factors are Q16
   localparam logic [25:0] LIN_BASE_NA = 26'h00093AE;
   localparam logic [25:0] LIN_STEP_NA = 26'h0002FA3;
   localparam logic [25:0] EXP_BASE_NA = 26'h000C350;
   localparam int EXP_FRAC = 16;
   localparam logic [20:0] EXP_MUL [11] = '{21'h0100C7, 21'h01018F, 21'h010321, 21'h01064B, 21'h010CBE,
      21'h011A1E, 21'h0136E7, 21'h017993, 21'h022CE7, 21'h04BB77, 21'h166502};
   localparam logic [3:0] MAP_LAST_STEP = 4'hB;

   typedef enum logic [2:0] {
      ST_DISABLED = 3'h1,
      ST_STANDBY = 3'h2,
      ST_ACTIVE = 3'h4
   } blec_state_t;

   typedef enum logic [8:0] {
      BS_IDLE = 9'h001,
      BS_ADDR = 9'h002,
      BS_AACK = 9'h004,
      BS_REG = 9'h008,
      BS_RACK = 9'h010,
      BS_WDAT = 9'h020,
      BS_WACK = 9'h040,
      BS_RDAT = 9'h080,
      BS_MACK = 9'h100
   } blec_bus_t;
endpackage : blec_pkg

/* src/blec_core.sv */
// Operation
// - While the hardware enable pin is low the core is disabled, registers sit at defaults and the bus is ignored.
// - Bus writes take effect only once the hardware enable pin is high, and the host raises it first.
// - Three sink enable bits in bits 3..1 of register string_and_chip_enable each enable one string.
// - After reset all three sink enable bits read as one.
// - After reset chip enable is one, pulse-width source is selected and linear mapping is used.
// - With defaults and the pin high the core waits in standby and turns a non-zero duty into the 11-bit code.
// - Standby keeps every programmed register value.
// - Chip enable at zero forces the disabled state with all LEDs off.
// - With the chip enabled, no sinks, a zero selected code, or a low pulse-width input in modes 01/1x mean standby.
// - Source 00 takes the bus brightness code and source 01 the pulse-width duty.
// - Sources 10 and 11 take the 11-bit product of bus code and duty.
// - Bit 7 of register brightness_mapping_config selects exponential (1) or linear (0) mapping.
// - Linear current is 37.806 uA plus 12.195 uA per code for codes 1..2047, and zero for code 0.
// - Exponential current is 50 uA times 1.003040572 to the code for codes 1..2047, and zero for code 0.
`timescale 1ns/1ps
module blec_core import blec_pkg::*; #(
   parameter logic [6:0] BUS_ADDR = 7'h2A,
   parameter int CODE_W = 11,
   parameter int NUM_SINKS = 3
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Pins
   input wire logic i_hardware_enable_pin,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   // Pulse-width sampler, same clock
   input wire logic [CODE_W-1:0] i_pwm_duty,
   // Analogue side
   output logic [2:0] o_state,
   output logic [NUM_SINKS-1:0] o_sink_en,
   output logic [CODE_W-1:0] o_code,
   output logic [25:0] o_led_na,
   output logic o_shutdown_quiescent_current
);
   logic scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q, hw1_q, hw2_q;
   blec_bus_t bst_q, bst_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
   logic rw_q, rw_d, nak_q, nak_d, oe_q, oe_d;
   logic [7:0] ctrl_q, ctrl_d, map_q, map_d;
   logic [CODE_W-1:0] brt_q, brt_d;
   logic wr_en;
   logic scl_rise, scl_fall, bus_start, bus_stop;

   assign scl_rise = scl2_q & ~scl3_q;
   assign scl_fall = ~scl2_q & scl3_q;
   assign bus_start = scl2_q & scl3_q & ~sda2_q & sda3_q;
   assign bus_stop = scl2_q & scl3_q & sda2_q & ~sda3_q;
   assign o_sda_o = 1'b0;

   blec_state_t st_q, st_d;

   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      rd_byte = 8'h00;
      unique case (a)
         REG_ENABLE_OFS: rd_byte = ctrl_q;
         REG_MAPCFG_OFS: rd_byte = map_q;
         REG_BRT_LO_OFS: rd_byte = {5'h00, brt_q[BRT_LO_W-1:0]};
         REG_BRT_HI_OFS: rd_byte = brt_q[CODE_W-1:BRT_LO_W];
         REG_STATUS_OFS: rd_byte = {5'h00, st_q};
         default: rd_byte = 8'h00;
      endcase
   endfunction : rd_byte

   // Serial bus slave and register file
   always_comb begin
      bst_d = bst_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      tx_d = tx_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      nak_d = nak_q;
      oe_d = oe_q;
      ctrl_d = ctrl_q;
      map_d = map_q;
      brt_d = brt_q;
      wr_en = 1'b0;
      if (!hw2_q) begin
         bst_d = BS_IDLE;
         oe_d = 1'b0;
         ptr_d = 8'h00;
         ctrl_d = ENABLE_RST;
         map_d = MAPCFG_RST;
         brt_d = BRT_RST;
      end else if (bus_start) begin
         bst_d = BS_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b0;
      end else if (bus_stop) begin
         bst_d = BS_IDLE;
         oe_d = 1'b0;
      end else if (scl_rise) begin
         unique case (bst_q)
            BS_ADDR, BS_REG, BS_WDAT: begin
               sh_d = {sh_q[6:0], sda2_q};
               cnt_d = cnt_q + 4'h1;
            end
            BS_RDAT: cnt_d = cnt_q + 4'h1;
            BS_MACK: nak_d = sda2_q;
            default: ;
         endcase
      end else if (scl_fall) begin
         unique case (bst_q)
            BS_ADDR: if (cnt_q == 4'h8) begin
               rw_d = sh_q[0];
               oe_d = (sh_q[7:1] == BUS_ADDR);
               bst_d = (sh_q[7:1] == BUS_ADDR) ? BS_AACK : BS_IDLE;
            end
            BS_AACK: begin
               cnt_d = 4'h0;
               if (rw_q) begin
                  tx_d = rd_byte(ptr_q);
                  oe_d = ~tx_d[7];
                  bst_d = BS_RDAT;
               end else begin
                  oe_d = 1'b0;
                  bst_d = BS_REG;
               end
            end
            BS_REG: if (cnt_q == 4'h8) begin
               ptr_d = sh_q;
               oe_d = 1'b1;
               bst_d = BS_RACK;
            end
            BS_RACK, BS_WACK: begin
               oe_d = 1'b0;
               cnt_d = 4'h0;
               bst_d = BS_WDAT;
            end
            BS_WDAT: if (cnt_q == 4'h8) begin
               wr_en = 1'b1;
               unique case (ptr_q)
                  REG_ENABLE_OFS: ctrl_d = sh_q & ENABLE_MASK;
                  REG_MAPCFG_OFS: map_d = sh_q & MAPCFG_MASK;
                  REG_BRT_LO_OFS: brt_d[BRT_LO_W-1:0] = sh_q[BRT_LO_W-1:0];
                  REG_BRT_HI_OFS: brt_d[CODE_W-1:BRT_LO_W] = sh_q;
                  default: ;
               endcase
               ptr_d = ptr_q + 8'h01;
               oe_d = 1'b1;
               bst_d = BS_WACK;
            end
            BS_RDAT: begin
               if (cnt_q == 4'h8) begin
                  oe_d = 1'b0;
                  bst_d = BS_MACK;
               end else begin
                  tx_d = {tx_q[6:0], 1'b0};
                  oe_d = ~tx_d[7];
               end
            end
            BS_MACK: begin
               cnt_d = 4'h0;
               if (nak_q) begin
                  oe_d = 1'b0;
                  bst_d = BS_IDLE;
               end else begin
                  ptr_d = ptr_q + 8'h01;
                  tx_d = rd_byte(ptr_d);
                  oe_d = ~tx_d[7];
                  bst_d = BS_RDAT;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         {scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q} <= 6'h3F;
         {hw1_q, hw2_q} <= 2'h0;
         bst_q <= BS_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         nak_q <= 1'b0;
         oe_q <= 1'b0;
         ctrl_q <= ENABLE_RST;
         map_q <= MAPCFG_RST;
         brt_q <= BRT_RST;
      end else if (i_ce) begin
         {scl1_q, scl2_q, scl3_q} <= {i_scl, scl1_q, scl2_q};
         {sda1_q, sda2_q, sda3_q} <= {i_sda, sda1_q, sda2_q};
         {hw1_q, hw2_q} <= {i_hardware_enable_pin, hw1_q};
         bst_q <= bst_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         nak_q <= nak_d;
         oe_q <= oe_d;
         ctrl_q <= ctrl_d;
         map_q <= map_d;
         brt_q <= brt_d;
      end
   end
   assign o_sda_oe = oe_q;

   // Operating state, code selection and current mapping
   logic [1:0] src_sel;
   logic [2*CODE_W-1:0] prod;
   logic [CODE_W-1:0] code_sel, code_d, snap_q, snap_d;
   logic [NUM_SINKS-1:0] sink_d, sink_q;
   logic [3:0] step_q, step_d;
   logic exps_q, exps_d, shdn_q, shdn_d;
   logic [25:0] acc_q, acc_d, led_q, led_d, code_q;
   logic [46:0] acc_mul;

   assign src_sel = map_q[SRC_SEL_LSB+1:SRC_SEL_LSB];
   assign prod = brt_q * i_pwm_duty;
   assign acc_mul = acc_q * EXP_MUL[step_q[3:0] - 4'h1];

   for (genvar i = 0; i < NUM_SINKS; i++) begin : g_sink
      assign sink_d[i] = (st_d == ST_ACTIVE) & ctrl_q[SINK_EN_LSB+i];
   end

   always_comb begin
      unique case (src_sel)
         SRC_BUS: code_sel = brt_q;
         SRC_PWM: code_sel = i_pwm_duty;
         default: code_sel = prod[2*CODE_W-1:CODE_W];
      endcase
      if (!hw2_q || !ctrl_q[CHIP_EN_BIT]) begin
         st_d = ST_DISABLED;
      end else if (ctrl_q[SINK_EN_LSB+NUM_SINKS-1:SINK_EN_LSB] == '0 || code_sel == '0 ||
                   (src_sel != SRC_BUS && i_pwm_duty == '0)) begin
         st_d = ST_STANDBY;
      end else begin
         st_d = ST_ACTIVE;
      end
      code_d = (st_d == ST_ACTIVE) ? code_sel : '0;
      shdn_d = (st_d != ST_ACTIVE);
      step_d = (step_q == MAP_LAST_STEP) ? 4'h0 : step_q + 4'h1;
      snap_d = snap_q;
      exps_d = exps_q;
      acc_d = acc_q;
      led_d = led_q;
      if (step_q == 4'h0) begin
         snap_d = code_q[CODE_W-1:0];
         exps_d = map_q[MAP_EXP_BIT];
         acc_d = EXP_BASE_NA;
      end else if (snap_q[step_q - 4'h1]) begin
         acc_d = acc_mul[EXP_FRAC+25:EXP_FRAC];
      end
      if (step_q == MAP_LAST_STEP) begin
         if (snap_q == '0) begin
            led_d = '0;
         end else if (exps_q) begin
            led_d = acc_d;
         end else begin
            led_d = LIN_BASE_NA + 26'(LIN_STEP_NA * snap_q);
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= ST_DISABLED;
         code_q <= '0;
         sink_q <= '0;
         shdn_q <= 1'b1;
         step_q <= 4'h0;
         snap_q <= '0;
         exps_q <= 1'b0;
         acc_q <= '0;
         led_q <= '0;
      end else if (i_ce) begin
         st_q <= st_d;
         code_q <= 26'(code_d);
         sink_q <= sink_d;
         shdn_q <= shdn_d;
         step_q <= step_d;
         snap_q <= snap_d;
         exps_q <= exps_d;
         acc_q <= acc_d;
         led_q <= led_d;
      end
   end
   assign o_state = st_q;
   assign o_code = code_q[CODE_W-1:0];
   assign o_sink_en = sink_q;
   assign o_led_na = led_q;
   assign o_shutdown_quiescent_current = shdn_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b || !i_ce);

   a_pin_low_disabled: assert property (!hw2_q |=> st_q == ST_DISABLED && bst_q == BS_IDLE)
      else $error("pin low but core not disabled");
   a_pin_low_defaults: assert property (!hw2_q |=> ctrl_q == ENABLE_RST && map_q == MAPCFG_RST)
      else $error("registers not at defaults");
   a_write_needs_pin: assert property (wr_en |-> hw2_q && $past(hw2_q, 1))
      else $error("write accepted with pin low");
   a_sink_enables: assert property (st_d == ST_ACTIVE |=> o_sink_en == $past(ctrl_q[3:1]))
      else $error("sink enables do not follow register");
   a_chip_off: assert property (!ctrl_q[CHIP_EN_BIT] |=> o_state == ST_DISABLED && o_sink_en == '0)
      else $error("chip enable low but not disabled");
   a_standby_cases: assert property (hw2_q && ctrl_q[0] && (ctrl_q[3:1] == 3'h0 || code_sel == '0)
      |=> o_state == ST_STANDBY && o_code == '0)
      else $error("standby condition ignored");
   a_default_pwm: assert property (hw2_q && ctrl_q == ENABLE_RST && map_q == MAPCFG_RST && i_pwm_duty != '0
      |=> o_state == ST_ACTIVE && o_code == $past(i_pwm_duty))
      else $error("duty not used as code");
   a_product_code: assert property (st_d == ST_ACTIVE && src_sel[1] |=> o_code == $past(prod[21:11]))
      else $error("product code wrong");
   a_standby_keeps: assert property (st_q == ST_STANDBY && hw2_q && !wr_en |=> $stable(ctrl_q) && $stable(brt_q))
      else $error("standby lost a register");
   a_linear_map: assert property (step_q == MAP_LAST_STEP && !exps_q && snap_q != '0
      |=> o_led_na == LIN_BASE_NA + 26'(LIN_STEP_NA * $past(snap_q)))
      else $error("linear current wrong");
   a_exp_first: assert property (step_q == 4'h0 && code_q == 26'h1 && map_q[7] |-> ##12 o_led_na == 26'h000C3E7)
      else $error("exponential step one wrong");

   c_pwm_active: cover property (st_q == ST_STANDBY ##1 st_q == ST_ACTIVE && src_sel == SRC_PWM);
   c_bus_write: cover property (wr_en && ptr_q == REG_BRT_HI_OFS);
   c_bus_read: cover property (bst_q == BS_MACK ##1 bst_q == BS_RDAT);
   c_exp_done: cover property (step_q == MAP_LAST_STEP && exps_q && snap_q == 11'h7FF);
endmodule : blec_core

/* testbench/blec_host.sv */
`timescale 1ns/1ps
module blec_host (
   // Clock
   input wire logic i_clock,
   // Serial bus
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #5;
   endtask : tick
   // Half periods of 8 clocks keep clear of the 5-clock minimum
   task automatic bit_io(input logic b, output logic r);
      o_sda_low = ~b;
      tick(4);
      o_scl = 1'b1;
      tick(7);
      r = i_sda;
      tick(1);
      o_scl = 1'b0;
      tick(4);
   endtask : bit_io
   // Serves as repeated start too, SCL may be low on entry
   task automatic start_c();
      o_sda_low = 1'b0;
      tick(4);
      o_scl = 1'b1;
      tick(8);
      o_sda_low = 1'b1;
      tick(8);
      o_scl = 1'b0;
      tick(4);
   endtask : start_c
   task automatic stop_c();
      o_sda_low = 1'b1;
      tick(4);
      o_scl = 1'b1;
      tick(8);
      o_sda_low = 1'b0;
      tick(8);
   endtask : stop_c
   task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(nine, a);
      ack = ~a;
   endtask : byte_io
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2;
      start_c();
      byte_io({dev, 1'b0}, 1'b1, q, a0);
      byte_io(ofs, 1'b1, q, a1);
      byte_io(d, 1'b1, q, a2);
      stop_c();
      ok = a0 & a1 & a2;
   endtask : write_reg
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2, a3;
      start_c();
      byte_io({dev, 1'b0}, 1'b1, q, a0);
      byte_io(ofs, 1'b1, q, a1);
      start_c();
      byte_io({dev, 1'b1}, 1'b1, q, a2);
      byte_io(8'hFF, 1'b1, d, a3);
      stop_c();
      ok = a0 & a1 & a2;
   endtask : read_reg
   // Two bytes from one pointer, master ACK between them
   task automatic read_pair(input logic [6:0] dev, input logic [7:0] ofs, output logic [15:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2, a3, a4;
      start_c();
      byte_io({dev, 1'b0}, 1'b1, q, a0);
      byte_io(ofs, 1'b1, q, a1);
      start_c();
      byte_io({dev, 1'b1}, 1'b1, q, a2);
      byte_io(8'hFF, 1'b0, d[15:8], a3);
      byte_io(8'hFF, 1'b1, d[7:0], a4);
      stop_c();
      ok = a0 & a1 & a2;
   endtask : read_pair
endmodule : blec_host

/* testbench/backlight_enable_brightness_control_test.sv */
`timescale 1ns/1ps
module backlight_enable_brightness_control_test;
   import blec_pkg::*;
   localparam logic [6:0] DEV = 7'h2A;
   logic clk, rst_b, ce, pin, scl, h_low, sda_w, sda_o, sda_oe, shd;
   logic [10:0] duty, code;
   logic [2:0] state, sink;
   logic [25:0] led;
   int bad_count, compares;
   // Open-drain wire with pull-up
   assign sda_w = (h_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
   blec_core #(.BUS_ADDR(DEV)) dut (.i_clock(clk), .i_rst_b(rst_b), .i_ce(ce), .i_hardware_enable_pin(pin),
      .i_scl(scl), .i_sda(sda_w), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_pwm_duty(duty), .o_state(state),
      .o_sink_en(sink), .o_code(code), .o_led_na(led), .o_shutdown_quiescent_current(shd));
   blec_host host (.i_clock(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(h_low));
   initial clk = 1'b0;
   always #50 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : tick
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] g);
      compares++;
      if (g !== e) begin
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
         bad_count++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic ok;
      host.write_reg(DEV, ofs, d, ok);
      chk("write ack", 1, ok);
   endtask : wr
   task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
      logic ok;
      logic [7:0] v;
      host.read_reg(DEV, ofs, v, ok);
      chk("read ack", 1, ok);
      chk("read data", e, v);
   endtask : rd
   // Mapping loop refreshes within 24 cycles of a code change
   task automatic chk_lin(input int c);
      tick(26);
      chk("led linear", (c == 0) ? 26'h0 : 26'(37806 + 12195 * c), led);
   endtask : chk_lin
   task automatic chk_exp(input int c);
      real e;
      tick(26);
      e = 50000.0 * (1.003040572 ** c);
      compares++;
      // Truncating fixed point, so a small tolerance
      if (real'(led) > e * 1.002 || real'(led) < e * 0.998) begin
         $display("ERROR led exp expected %0f seen %0d", e, led);
         bad_count++;
      end
   endtask : chk_exp
   task automatic t_defaults();
      logic ok;
      logic [15:0] pair;
      chk("state", ST_STANDBY, state);
      chk("shutdown", 1, shd);
      rd(REG_ENABLE_OFS, 8'h0F);
      rd(REG_MAPCFG_OFS, 8'h01);
      rd(REG_STATUS_OFS, 8'h02);
      rd(8'h20, 8'h00);
      // Burst read walks the pointer on the master ACK
      host.read_pair(DEV, REG_ENABLE_OFS, pair, ok);
      chk("burst ack", 1, ok);
      chk("burst data", 16'h0F01, pair);
   endtask : t_defaults
   task automatic t_pwm();
      duty = 11'h400;
      chk_lin(11'h400);
      chk("state", ST_ACTIVE, state);
      chk("code", 11'h400, code);
      chk("sinks", 3'h7, sink);
      chk("shutdown", 0, shd);
   endtask : t_pwm
   task automatic t_bus();
      wr(REG_MAPCFG_OFS, 8'h00);
      wr(REG_BRT_HI_OFS, 8'hFF);
      wr(REG_BRT_LO_OFS, 8'h07);
      chk("code", 11'h7FF, code);
      chk_lin(2047);
      wr(REG_BRT_HI_OFS, 8'h00);
      wr(REG_BRT_LO_OFS, 8'h00);
      chk("state", ST_STANDBY, state);
      chk_lin(0);
      wr(REG_BRT_LO_OFS, 8'h01);
      chk_lin(1);
      wr(REG_MAPCFG_OFS, 8'h80);
      chk_exp(1);
      wr(REG_BRT_HI_OFS, 8'hFF);
      wr(REG_BRT_LO_OFS, 8'h07);
      chk_exp(2047);
   endtask : t_bus
   task automatic t_product();
      wr(REG_MAPCFG_OFS, 8'h02);
      wr(REG_BRT_HI_OFS, 8'h80);
      wr(REG_BRT_LO_OFS, 8'h00);
      chk("code", 11'h200, code);
      chk_lin(11'h200);
      wr(REG_MAPCFG_OFS, 8'h03);
      chk("code", 11'h200, code);
      duty = 11'h000;
      tick(3);
      chk("state", ST_STANDBY, state);
      wr(REG_MAPCFG_OFS, 8'h01);
      chk("state", ST_STANDBY, state);
      duty = 11'h400;
   endtask : t_product
   task automatic t_sinks();
      wr(REG_ENABLE_OFS, 8'h03);
      chk("sinks", 3'h1, sink);
      wr(REG_ENABLE_OFS, 8'h01);
      chk("state", ST_STANDBY, state);
      rd(REG_ENABLE_OFS, 8'h01);
      rd(REG_MAPCFG_OFS, 8'h01);
      wr(REG_ENABLE_OFS, 8'h0E);
      chk("state", ST_DISABLED, state);
      chk("sinks", 3'h0, sink);
      chk_lin(0);
      wr(REG_ENABLE_OFS, 8'h0F);
   endtask : t_sinks
   task automatic t_pin();
      logic ok;
      host.write_reg(7'h2B, REG_MAPCFG_OFS, 8'h80, ok);
      chk("foreign address ack", 0, ok);
      wr(REG_MAPCFG_OFS, 8'h80);
      pin = 1'b0;
      tick(5);
      chk("state", ST_DISABLED, state);
      chk("shutdown", 1, shd);
      host.write_reg(DEV, REG_MAPCFG_OFS, 8'h00, ok);
      chk("ack pin low", 0, ok);
      pin = 1'b1;
      tick(5);
      rd(REG_MAPCFG_OFS, 8'h01);
      chk("state", ST_ACTIVE, state);
   endtask : t_pin
   initial begin
      bad_count = 0;
      compares = 0;
      rst_b = 1'b0;
      ce = 1'b1;
      pin = 1'b1;
      duty = 11'h000;
      repeat (10) @(posedge clk);
      #5;
      rst_b = 1'b1;
      tick(5);
      t_defaults();
      t_pwm();
      t_bus();
      t_product();
      t_sinks();
      t_pin();
      give_verdict();
   end
   // About 15k cycles of traffic expected
   initial begin
      #6000000;
      bad_count++;
      give_verdict();
   end
endmodule : backlight_enable_brightness_control_test
